// ==== logic/vip_params.svh ====
`ifndef VIP_PARAMS_SVH
`define VIP_PARAMS_SVH

// ****************************************************************
// Register offsets on the bus (byte addresses, low eight bits)
// ****************************************************************
`define VIP_OFF_FLAGS 8'h00
`define VIP_OFF_LOCAL_EN 8'h04
`define VIP_OFF_CTRL 8'h08
`define VIP_OFF_INT_STATUS 8'h0C
`define VIP_OFF_INT_CLEAR 8'h10
`define VIP_OFF_INT_ENABLE 8'h14
`define VIP_OFF_ENTRY 8'h18

// Bit 7 of the offset selects the vector table window, bits 6:2 the slot.
`define VIP_VEC_SEL_BIT 7

// ****************************************************************
// Field positions
// ****************************************************************
`define VIP_CTRL_MASK_BIT 0
`define VIP_CTRL_WDOG_EN_BIT 1
`define VIP_CTRL_LV_EN_BIT 2
`define VIP_INT_ENTRY_BIT 0
`define VIP_INT_RESET_BIT 1
`define VIP_ENTRY_BUSY_BIT 8

// ****************************************************************
// Reset values and fixed table facts
// ****************************************************************
`define VIP_CTRL_RESET 3'h7
`define VIP_SLOT_ASSIGNED 32'h47B7F868
`define VIP_SLOT_RESET 5'h00
`define VIP_SLOT_TRAP 5'h01
`define VIP_VEC_TOP 16'hFFFE
`define VIP_PUSH_LAST 3'h4
`define VIP_HRESP_OKAY 1'h0

`endif

// ==== logic/vip_pkg.sv ====
package vip_pkg;

   typedef logic [4:0] vip_slot_t;
   typedef logic [15:0] vip_vec_t;

   typedef enum logic [3:0] {
      VIP_IDLE = 4'b0001,
      VIP_PUSH = 4'b0010,
      VIP_FETCH = 4'b0100,
      VIP_LOAD = 4'b1000
   } vip_seq_state_e;

endpackage

// ==== logic/vip_vec_if.sv ====
`timescale 1ns/1ps

interface vip_vec_if;
   logic wr_en;
   vip_pkg::vip_slot_t wr_slot;
   vip_pkg::vip_vec_t wr_data;
   vip_pkg::vip_slot_t rda_slot;
   vip_pkg::vip_vec_t rda_data;
   vip_pkg::vip_slot_t rdb_slot;
   vip_pkg::vip_vec_t rdb_data;

   modport ctrl (
      output wr_en, wr_slot, wr_data, rda_slot, rdb_slot,
      input rda_data, rdb_data
   );

   modport mem (
      input wr_en, wr_slot, wr_data, rda_slot, rdb_slot,
      output rda_data, rdb_data
   );
endinterface

// ==== logic/vip_vector_table.sv ====
`timescale 1ns/1ps

module vip_vector_table (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Table access
   vip_vec_if.mem vt
);

   vip_pkg::vip_vec_t slot_reg [0:31];

   // ****************************************************************
   // Storage, one word per slot, high byte in bits 15:8
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : g_slot
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               slot_reg[g] <= 16'h0000;
            end else if (vt.wr_en && (vt.wr_slot == 5'(g))) begin
               slot_reg[g] <= vt.wr_data;
            end
         end
      end
   endgenerate

   // Both read ports are registered so that bus and fetch never contend.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vt.rda_data <= 16'h0000;
         vt.rdb_data <= 16'h0000;
      end else begin
         vt.rda_data <= slot_reg[vt.rda_slot];
         vt.rdb_data <= slot_reg[vt.rdb_slot];
      end
   end

endmodule // vip_vector_table

// ==== logic/vip_top.sv ====
//
// Contract
// R1: Source event sets its flag regardless of enable.
// R2: Request only while flag set and enabled.
// R3: Maskable entry only at boundary, mask clear.
// R4: Push low PC, high PC, X, A, CONDITION_CODE_REGISTER; mask.
// R5: After stacking fetch highest pending vector, jump.
// R6: Lower vector number always wins priority.
// R7: Vector high byte at lower address.
// R8: Thirty-two slots at 0xFFFE minus 2n.
// R9: Slot 0 collects all gated reset causes.
// R10: Reset sets the global mask bit.
// R11: Software clears source flag before returning.
// R12: Software trap taken regardless of enables, mask.
//
`timescale 1ns/1ps
`include "vip_params.svh"

module vip_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Peripheral event pulses, one per slot
   input wire logic [31:0] src_event,
   // Reset causes
   input wire logic watchdog_timeout,
   input wire logic low_voltage_detect,
   input wire logic reset_pin_n,
   input wire logic illegal_opcode,
   input wire logic illegal_address,
   // Core side
   input wire logic instr_boundary,
   input wire logic software_trap_instruction,
   input wire logic [15:0] core_sp,
   input wire logic [15:0] core_pc,
   input wire logic [7:0] core_x,
   input wire logic [7:0] core_a,
   input wire logic [7:0] condition_code_register,
   // Entry sequence outputs
   output logic stack_we,
   output logic [15:0] stack_addr,
   output logic [7:0] stack_data,
   output logic pc_load,
   output logic [15:0] new_pc,
   output logic [15:0] vector_addr,
   output logic entry_busy,
   output logic global_mask,
   output logic irq
);

   vip_vec_if vt ();

   vip_vector_table u_table (
      .hclk(hclk),
      .hresetn(hresetn),
      .vt(vt)
   );

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic dp_write_reg;
   logic dp_read_reg;
   logic [7:0] dp_addr_reg;
   logic [31:0] flag_reg;
   logic [31:0] local_en_reg;
   logic [2:0] ctrl_reg;
   logic [1:0] int_status_reg;
   logic [1:0] int_en_reg;
   logic [4:0] last_slot_reg;

   wire addr_take = hsel & htrans[1] & hready;
   wire wr_fire = dp_write_reg & hready;
   wire wr_vec = wr_fire & dp_addr_reg[`VIP_VEC_SEL_BIT];
   wire wr_flags = wr_fire & (dp_addr_reg == `VIP_OFF_FLAGS);
   wire wr_local_en = wr_fire & (dp_addr_reg == `VIP_OFF_LOCAL_EN);
   wire wr_ctrl = wr_fire & (dp_addr_reg == `VIP_OFF_CTRL);
   wire wr_int_clr = wr_fire & (dp_addr_reg == `VIP_OFF_INT_CLEAR);
   wire wr_int_en = wr_fire & (dp_addr_reg == `VIP_OFF_INT_ENABLE);

   assign vt.wr_en = wr_vec;
   assign vt.wr_slot = dp_addr_reg[6:2];
   assign vt.wr_data = hwdata[15:0]; // [R7]
   // The slot is steered from the address phase so the word is ready for the wait cycle.
   assign vt.rda_slot = addr_take ? haddr[6:2] : dp_addr_reg[6:2];

   wire [31:0] rd_mux =
      dp_addr_reg[`VIP_VEC_SEL_BIT] ? {16'h0000, vt.rda_data} :
      (dp_addr_reg == `VIP_OFF_FLAGS) ? flag_reg :
      (dp_addr_reg == `VIP_OFF_LOCAL_EN) ? local_en_reg :
      (dp_addr_reg == `VIP_OFF_CTRL) ? {29'h0, ctrl_reg} :
      (dp_addr_reg == `VIP_OFF_INT_STATUS) ? {30'h0, int_status_reg} :
      (dp_addr_reg == `VIP_OFF_INT_ENABLE) ? {30'h0, int_en_reg} :
      (dp_addr_reg == `VIP_OFF_ENTRY) ? {23'h0, entry_busy, 3'h0, last_slot_reg} :
      32'h00000000;

   // Reads take one wait state so that read data always leaves a flip-flop.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_reg <= 1'b0;
         dp_read_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
         hresp <= `VIP_HRESP_OKAY;
      end else if (dp_read_reg && !hreadyout) begin
         hrdata <= rd_mux;
         hreadyout <= 1'b1;
         dp_read_reg <= 1'b0;
      end else begin
         dp_write_reg <= addr_take & hwrite;
         dp_read_reg <= addr_take & ~hwrite;
         hreadyout <= ~(addr_take & ~hwrite);
         if (addr_take) begin
            dp_addr_reg <= {haddr[7:2], 2'b00};
         end
      end
   end

   // ****************************************************************
   // Reset causes and pending requests
   // ****************************************************************
   logic pin_sync1_reg;
   logic pin_sync2_reg;
   logic reset_pend_reg;
   logic trap_pend_reg;
   vip_pkg::vip_seq_state_e state_reg;
   logic [4:0] slot_reg;

   wire load_now = (state_reg == vip_pkg::VIP_LOAD);
   wire reset_req = (watchdog_timeout & ctrl_reg[`VIP_CTRL_WDOG_EN_BIT])
      | (low_voltage_detect & ctrl_reg[`VIP_CTRL_LV_EN_BIT])
      | ~pin_sync2_reg | illegal_opcode | illegal_address; // [R9]
   wire reset_clr = load_now & (slot_reg == `VIP_SLOT_RESET);
   wire trap_clr = load_now & (slot_reg == `VIP_SLOT_TRAP);

   wire [31:0] flag_clr = wr_flags ? hwdata : 32'h00000000; // [R11]
   wire [31:0] flag_next = (flag_reg & ~flag_clr) | (src_event & `VIP_SLOT_ASSIGNED); // [R1]
   wire [31:0] maskable_pend = flag_reg & local_en_reg & `VIP_SLOT_ASSIGNED; // [R2] [R8]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_sync1_reg <= 1'b1;
         pin_sync2_reg <= 1'b1;
         reset_pend_reg <= 1'b0;
         trap_pend_reg <= 1'b0;
         flag_reg <= 32'h00000000;
         local_en_reg <= 32'h00000000;
      end else begin
         pin_sync1_reg <= reset_pin_n;
         pin_sync2_reg <= pin_sync1_reg;
         reset_pend_reg <= reset_req | (reset_pend_reg & ~reset_clr);
         trap_pend_reg <= software_trap_instruction | (trap_pend_reg & ~trap_clr); // [R12]
         flag_reg <= flag_next;
         if (wr_local_en) begin
            local_en_reg <= hwdata;
         end
      end
   end

   // ****************************************************************
   // Priority selection
   // ****************************************************************
   // Lowest slot number wins; the loop runs downward so the last hit is the lowest.
   function automatic logic [4:0] vip_pick(input logic [31:0] pend);
      logic [4:0] win;
      win = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (pend[i]) begin
            win = 5'(i);
         end
      end
      return win;
   endfunction

   logic unmasked_reg;
   logic [2:0] push_idx_reg;

   wire mask_bit = ctrl_reg[`VIP_CTRL_MASK_BIT];
   wire [31:0] entry_pend = {maskable_pend[31:2] & {30{~mask_bit}}, trap_pend_reg, 1'b0};
   wire [31:0] fetch_pend = {maskable_pend[31:2] & {30{unmasked_reg}}, trap_pend_reg,
      reset_pend_reg};
   wire entry_req = instr_boundary & (|entry_pend); // [R3] [R12]
   wire [4:0] entry_slot = vip_pick(entry_pend); // [R6]
   wire [4:0] fetch_slot = (|fetch_pend) ? vip_pick(fetch_pend) : slot_reg; // [R5] [R6]
   assign vt.rdb_slot = fetch_slot;

   wire [7:0] push_byte =
      (push_idx_reg == 3'h0) ? core_pc[7:0] :
      (push_idx_reg == 3'h1) ? core_pc[15:8] :
      (push_idx_reg == 3'h2) ? core_x :
      (push_idx_reg == 3'h3) ? core_a :
      condition_code_register; // [R4]
   wire push_done = (state_reg == vip_pkg::VIP_PUSH) & (push_idx_reg == `VIP_PUSH_LAST);
   wire reset_entry = (state_reg == vip_pkg::VIP_IDLE) & reset_pend_reg;

   // ****************************************************************
   // Entry sequencer
   // ****************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= vip_pkg::VIP_IDLE;
         slot_reg <= 5'h00;
         last_slot_reg <= 5'h00;
         unmasked_reg <= 1'b0;
         push_idx_reg <= 3'h0;
         stack_we <= 1'b0;
         stack_addr <= 16'h0000;
         stack_data <= 8'h00;
         pc_load <= 1'b0;
         new_pc <= 16'h0000;
         vector_addr <= 16'h0000;
         entry_busy <= 1'b0;
      end else begin
         stack_we <= 1'b0;
         pc_load <= 1'b0;
         case (state_reg)
            vip_pkg::VIP_IDLE: begin
               if (reset_pend_reg) begin
                  // Reset needs no frame, so it skips straight to the fetch.
                  slot_reg <= `VIP_SLOT_RESET; // [R9]
                  unmasked_reg <= 1'b0;
                  entry_busy <= 1'b1;
                  state_reg <= vip_pkg::VIP_FETCH;
               end else if (entry_req) begin
                  slot_reg <= entry_slot;
                  unmasked_reg <= ~mask_bit;
                  push_idx_reg <= 3'h0;
                  entry_busy <= 1'b1;
                  state_reg <= vip_pkg::VIP_PUSH; // [R3]
               end
            end
            vip_pkg::VIP_PUSH: begin
               stack_we <= 1'b1;
               stack_addr <= core_sp - {13'h0000, push_idx_reg}; // [R4]
               stack_data <= push_byte; // [R4]
               push_idx_reg <= push_idx_reg + 3'h1;
               if (push_done) begin
                  state_reg <= vip_pkg::VIP_FETCH;
               end
            end
            vip_pkg::VIP_FETCH: begin
               slot_reg <= fetch_slot; // [R5]
               vector_addr <= `VIP_VEC_TOP - {10'h000, fetch_slot, 1'b0}; // [R8]
               state_reg <= vip_pkg::VIP_LOAD;
            end
            vip_pkg::VIP_LOAD: begin
               new_pc <= vt.rdb_data; // [R5] [R7]
               pc_load <= 1'b1;
               last_slot_reg <= slot_reg;
               entry_busy <= 1'b0;
               state_reg <= vip_pkg::VIP_IDLE;
            end
            default: begin
               state_reg <= vip_pkg::VIP_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Control register, global mask and interrupt line
   // ****************************************************************
   // Hardware setting the mask wins over a software clear in the same cycle.
   wire mask_set = push_done | reset_entry; // [R4] [R10]
   wire [2:0] ctrl_wr_val = wr_ctrl ? hwdata[2:0] : ctrl_reg;
   wire [2:0] ctrl_next = {ctrl_wr_val[2:1], ctrl_wr_val[0] | mask_set};
   wire [1:0] int_ev = {reset_clr, load_now};
   wire [1:0] int_clr = wr_int_clr ? hwdata[1:0] : 2'b00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `VIP_CTRL_RESET; // [R10]
         int_status_reg <= 2'b00;
         int_en_reg <= 2'b00;
         global_mask <= 1'b1;
         irq <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         int_status_reg <= (int_status_reg & ~int_clr) | int_ev;
         if (wr_int_en) begin
            int_en_reg <= hwdata[1:0];
         end
         global_mask <= ctrl_next[`VIP_CTRL_MASK_BIT];
         irq <= |(int_status_reg & int_en_reg);
      end
   end

endmodule // vip_top

// ==== sim/vip_chk.sv ====
`timescale 1ns/1ps

// ****
// Entry sequence checks
// ****
module vip_chk (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Core side
   input wire logic software_trap_instruction,
   input wire logic [15:0] core_sp,
   input wire logic [15:0] core_pc,
   // Entry outputs
   input wire logic stack_we,
   input wire logic [15:0] stack_addr,
   input wire logic [7:0] stack_data,
   input wire logic pc_load,
   input wire logic [15:0] vector_addr,
   input wire logic entry_busy,
   input wire logic global_mask
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_push_five: assert property ($rose(stack_we) |-> stack_we [*5] ##1 !stack_we)
      else $error("push count wrong");
   a_push_order: assert property (stack_we && $past(stack_we)
      |-> stack_addr == $past(stack_addr) - 16'h0001)
      else $error("push address order wrong");
   a_first_byte: assert property ($rose(stack_we)
      |-> stack_addr == core_sp && stack_data == core_pc[7:0])
      else $error("first pushed byte wrong");
   a_push_busy: assert property (stack_we |-> entry_busy)
      else $error("push outside entry");
   a_mask_set: assert property ($fell(stack_we) |-> ##[0:1] global_mask)
      else $error("mask not set after push");
   a_vec_slot: assert property (pc_load |-> vector_addr[15:6] == 10'h3FF && !vector_addr[0])
      else $error("vector address outside table");
   a_load_bound: assert property ($rose(entry_busy) |-> ##[2:7] pc_load)
      else $error("no load after entry");
   a_load_ends: assert property (pc_load |-> !entry_busy && $past(entry_busy))
      else $error("load not at end of entry");
   a_reset_mask: assert property ($rose(hresetn) |-> global_mask)
      else $error("mask clear after reset");
   a_trap_taken: assert property (software_trap_instruction |-> ##[1:14] entry_busy)
      else $error("trap not taken");
endmodule // vip_chk

// ==== sim/vip_core_model.sv ====
`timescale 1ns/1ps

// ****
// Core entry sequencer model
// ****
module vip_core_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bench command
   input wire logic trap_go,
   // Entry link
   input wire logic entry_busy,
   input wire logic pc_load,
   input wire logic [15:0] new_pc,
   output logic instr_boundary,
   output logic software_trap_instruction,
   output logic [15:0] core_sp,
   output logic [15:0] core_pc,
   output logic [7:0] core_x,
   output logic [7:0] core_a,
   output logic [7:0] condition_code_register
);
   logic [1:0] phase_reg;

   // The stack pointer stays fixed, so every frame lands on the same bytes.
   assign core_sp = 16'h047F;
   assign core_x = 8'h5A;
   assign core_a = 8'hA5;
   assign condition_code_register = 8'h60;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg <= 2'h0;
         instr_boundary <= 1'b0;
         software_trap_instruction <= 1'b0;
         core_pc <= 16'h2000;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         // Each instruction takes four cycles and ends only outside an entry.
         instr_boundary <= (phase_reg == 2'h3) && !entry_busy;
         software_trap_instruction <= trap_go;
         if (pc_load) begin
            core_pc <= new_pc;
         end
      end
   end
endmodule // vip_core_model

// ==== sim/test_vectored_interrupt_priority.sv ====
`timescale 1ns/1ps

// ****
// Bench
// ****
module test_vectored_interrupt_priority;
   logic hclk, hresetn, hsel, hwrite, trap_go, hreadyout, hresp, irq;
   logic stack_we, pc_load, entry_busy, global_mask, instr_boundary;
   logic software_trap_instruction;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, src_event, rd;
   logic [4:0] cause_q;
   logic [15:0] stack_addr, new_pc, vector_addr, core_sp, core_pc;
   logic [7:0] stack_data, core_x, core_a, condition_code_register;
   int fails, checks, i;

   vip_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_event,
      .watchdog_timeout(cause_q[0]), .low_voltage_detect(cause_q[1]),
      .reset_pin_n(!cause_q[2]), .illegal_opcode(cause_q[3]), .illegal_address(cause_q[4]),
      .instr_boundary, .software_trap_instruction, .core_sp, .core_pc, .core_x, .core_a,
      .condition_code_register, .stack_we, .stack_addr, .stack_data, .pc_load,
      .new_pc, .vector_addr, .entry_busy, .global_mask, .irq);

   vip_core_model core (.hclk, .hresetn, .trap_go, .entry_busy, .pc_load, .new_pc,
      .instr_boundary, .software_trap_instruction, .core_sp, .core_pc, .core_x, .core_a,
      .condition_code_register);

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) begin
         fails++;
         final_report();
      end
   endtask

   task wait_load;
      int n;
      n = 0;
      do begin @(posedge hclk); n++; end while (pc_load !== 1'b1 && n < 60);
      if (n >= 60) begin
         fails++;
         final_report();
      end
   endtask

   task quiet(input string n);
      logic seen;
      seen = 1'b0;
      repeat (20) begin
         @(posedge hclk);
         seen = seen | (entry_busy !== 1'b0);
      end
      chk(n, {31'h0, seen}, 32'h0);
   endtask

   task pulse_ev(input logic [31:0] m);
      @(posedge hclk);
      src_event <= m;
      @(posedge hclk);
      src_event <= 32'h0;
   endtask

   task t_reset;
      bus(1'b0, 8'h08, 32'h0);
      chk("ctrl", rd, 32'h7);
      chk("mask", {31'h0, global_mask}, 32'h1);
      chk("hresp", {31'h0, hresp}, 32'h0);
      bus(1'b0, 8'h1C, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (i = 0; i < 32; i++) bus(1'b1, 8'(8'h80 + 4 * i), 32'hA000 + i);
      bus(1'b0, 8'h94, 32'h0);
      chk("slot5", rd, 32'hA005);
      $display("reset test done");
   endtask

   task t_masked;
      bus(1'b1, 8'h04, 32'h0010_0020);
      pulse_ev(32'h0000_0020);
      bus(1'b0, 8'h00, 32'h0);
      chk("flag5", rd, 32'h20);
      quiet("masked entry");
      $display("masked test done");
   endtask

   task t_priority;
      pulse_ev(32'h0010_0008);
      bus(1'b1, 8'h08, 32'h6);
      wait_load();
      chk("vec5", {16'h0000, vector_addr}, 32'h0000FFF4);
      chk("pc5", {16'h0000, new_pc}, 32'h0000A005);
      bus(1'b0, 8'h08, 32'h0);
      chk("mask on", rd, 32'h7);
      bus(1'b1, 8'h00, 32'h20);
      bus(1'b1, 8'h08, 32'h6);
      wait_load();
      chk("vec20", {16'h0000, vector_addr}, 32'h0000FFD6);
      chk("pc20", {16'h0000, new_pc}, 32'h0000A014);
      bus(1'b1, 8'h00, 32'h0010_0000);
      bus(1'b1, 8'h08, 32'h6);
      quiet("disabled flag");
      $display("priority test done");
   endtask

   task t_trap;
      bus(1'b1, 8'h08, 32'h7);
      // Earlier entries left the done bit set, so clear it to make irq depend on the trap.
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b1, 8'h14, 32'h1);
      chk("irq idle", {31'h0, irq}, 32'h0);
      @(posedge hclk);
      trap_go <= 1'b1;
      @(posedge hclk);
      trap_go <= 1'b0;
      wait_load();
      chk("vec trap", {16'h0000, vector_addr}, 32'h0000FFFC);
      chk("pc trap", {16'h0000, new_pc}, 32'h0000A001);
      @(posedge hclk);
      chk("irq on", {31'h0, irq}, 32'h1);
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b0, 8'h0C, 32'h0);
      chk("status clr", rd, 32'h0);
      chk("irq off", {31'h0, irq}, 32'h0);
      bus(1'b0, 8'h18, 32'h0);
      chk("entry slot", rd, 32'h1);
      $display("trap test done");
   endtask

   task t_causes;
      bus(1'b1, 8'h14, 32'h2);
      for (i = 0; i < 5; i++) begin
         @(posedge hclk);
         cause_q <= 5'(1 << i);
         repeat (2) @(posedge hclk);
         cause_q <= 5'h00;
         wait_load();
         chk("vec reset", {16'h0000, vector_addr}, 32'h0000FFFE);
         chk("pc reset", {16'h0000, new_pc}, 32'h0000A000);
      end
      bus(1'b0, 8'h0C, 32'h0);
      // A reset load is an entry too, so the done bit is set alongside the reset bit.
      chk("reset status", rd, 32'h3);
      chk("irq reset", {31'h0, irq}, 32'h1);
      bus(1'b1, 8'h10, 32'h2);
      bus(1'b1, 8'h08, 32'h5);
      @(posedge hclk);
      cause_q <= 5'h01;
      @(posedge hclk);
      cause_q <= 5'h00;
      quiet("gated watchdog");
      $display("cause test done");
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      src_event = 32'h0;
      cause_q = 5'h00;
      trap_go = 1'b0;
      fails = 0;
      checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_masked();
      t_priority();
      t_trap();
      t_causes();
      final_report();
   end
endmodule // test_vectored_interrupt_priority

bind vip_top vip_chk u_chk (.hclk, .hresetn, .software_trap_instruction, .core_sp, .core_pc,
   .stack_we, .stack_addr, .stack_data, .pc_load, .vector_addr, .entry_busy, .global_mask);
